// *** logic/guest_exit_pkg.sv ***
// constants and types for the guest exit state save block
// Function
// - record pre-exit activity state into activity save field on every exit
// - clear saved smi blocking bit 2 when exit does not end in smm
// - bit 3 shows virtual nmi blocking when virtual nmi control set
// - pending debug saved zero except listed event, reason and blocking exits
// - bits 3:0 may show matched breakpoints, even disabled ones
// - event-caused exits set bits for every pending debug cause
// - exit right after entry may save the value entry loaded
// - bit 12 set on enabled data/io match or undelivered entry value
// - bit 14 set when trap flag and matching step or branch cause
// - under stack-move blocking never set bit 14 if tf 0 or btf 1; code applies this only when there is no event or reason keep
// - reserved pending debug bits always cleared
// - save decremented timer only when save-timer control is 1
// - timer expiry exits save timer value zero
// - save four entries in use when ept enabled and pae paging active
// - entry bits 11:9 undefined; present entries hold guest-physical address
// - entries undefined when ept off or pae paging unused
// - walk store list in order up to count, write value to 127:64
// - entry fails when index bits 31:8 equal 000008h
// - entry fails on smm-only register outside smm or model-barred register
// - entry fails when bits 63:32 nonzero
// - entry fails when read at privilege 0 would fault
// - any failing entry raises a virtualization abort
package guest_exit_pkg;
    localparam int          ACT_W          = 32;
    localparam int          INTR_W         = 32;
    localparam int          DBG_W          = 64;
    localparam int          TMR_W          = 32;
    localparam int          PDPE_W         = 64;
    localparam int          PDPE_N         = 4;
    localparam int          SMI_BLK_BIT    = 2;
    localparam int          NMI_BLK_BIT    = 3;
    localparam int          DBG_ENBP_BIT   = 12;
    localparam int          DBG_BS_BIT     = 14;
    localparam logic [63:0] DBG_VALID_MASK = 64'h0000_0000_0000_500f;
    localparam logic [23:0] APIC_IDX_HI    = 24'h000008;
    localparam int          IDX_W          = 32;
    localparam int          CNT_W          = 16;
    localparam logic [TMR_W-1:0] TMR_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {ST_IDLE, ST_SAVE, ST_REQ, ST_WAIT, ST_DONE} state_type;
endpackage

// *** logic/guest_exit_state_save.sv ***
// guest exit non-register state save and exit store list walk
module guest_exit_state_save
    import guest_exit_pkg::*;
#(
    parameter int LIST_MAX = 512
) (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic                         exit_start,
    input  wire logic [guest_exit_pkg::ACT_W-1:0]  activity_state,
    input  wire logic [guest_exit_pkg::INTR_W-1:0] interruptibility,
    input  wire logic                         virtual_nmi_ctl,
    input  wire logic                         virtual_nmi_blocked,
    input  wire logic                         exit_ends_in_smm,
    input  wire logic                         exit_event_cause,
    input  wire logic                         exit_reason_keep,
    input  wire logic                         exit_is_debug,
    input  wire logic                         stack_move_debug_blocking,
    input  wire logic                         exit_after_entry,
    input  wire logic [guest_exit_pkg::DBG_W-1:0]  entry_pending_debug,
    input  wire logic [3:0]                   matched_breakpoints,
    input  wire logic                         enabled_data_io_match,
    input  wire logic                         entry_bp_undelivered,
    input  wire logic                         trap_flag_setting,
    input  wire logic                         branch_trap_setting,
    input  wire logic                         single_step_cause,
    input  wire logic                         taken_branch_cause,
    input  wire logic                         save_timer_ctl,
    input  wire logic                         timer_expiry_exit,
    input  wire logic [guest_exit_pkg::TMR_W-1:0]  timer_value,
    input  wire logic                         ept_supported,
    input  wire logic                         ept_enabled,
    input  wire logic                         pae_paging_active,
    input  wire logic [guest_exit_pkg::PDPE_W*guest_exit_pkg::PDPE_N-1:0] pdpe_in_use,
    input  wire logic [guest_exit_pkg::CNT_W-1:0]  store_count,
    output logic                              list_rd_req,
    output logic [guest_exit_pkg::CNT_W-1:0]       list_index,
    input  wire logic                         list_rd_valid,
    input  wire logic [63:0]                  list_entry_lo,
    output logic                              msr_rd_req,
    output logic [guest_exit_pkg::IDX_W-1:0]       msr_index,
    input  wire logic                         msr_rd_valid,
    input  wire logic [63:0]                  msr_value,
    input  wire logic                         msr_smm_only,
    input  wire logic                         msr_barred,
    input  wire logic                         msr_gp_fault,
    output logic                              list_wr_en,
    output logic [63:0]                       list_wr_value,
    output logic [guest_exit_pkg::ACT_W-1:0]       saved_activity,
    output logic [guest_exit_pkg::INTR_W-1:0]      saved_interruptibility,
    output logic [guest_exit_pkg::DBG_W-1:0]       saved_pending_debug,
    output logic [guest_exit_pkg::TMR_W-1:0]       saved_timer,
    output logic [guest_exit_pkg::PDPE_W*guest_exit_pkg::PDPE_N-1:0] saved_pdpe,
    output logic                              pdpe_saved,
    output logic                              virt_abort,
    output logic                              exit_done
);
    import guest_exit_pkg::*;

    if (LIST_MAX < 1 || LIST_MAX > (1 << CNT_W) - 1) begin : g_list_max_check
        $error("LIST_MAX out of range");
    end

    state_type             state_r;
    state_type             state_nxt;
    logic [CNT_W-1:0]      idx_r;
    logic [CNT_W-1:0]      cnt_r;
    logic [IDX_W-1:0]      msr_idx_r;
    logic                  smm_r;
    logic                  abort_r;
    logic [63:0]           wr_val_r;
    logic                  wr_en_r;

    // pending debug composition
    wire logic dbg_keep      = exit_event_cause | exit_reason_keep
                             | (~exit_is_debug & stack_move_debug_blocking);
    wire logic bs_event      = trap_flag_setting & ((~branch_trap_setting & single_step_cause)
                             | (branch_trap_setting & taken_branch_cause));
    // implementation choice for blocking-only exits (no event or reason keep): single-step term only, without the taken-branch term, so tf 0 / btf 1 never set bit 14
    wire logic bs_blk        = trap_flag_setting & ~branch_trap_setting & single_step_cause;
    wire logic bs_bit        = (exit_event_cause | exit_reason_keep) ? bs_event : bs_blk;
    wire logic enbp_bit      = enabled_data_io_match | entry_bp_undelivered;
    logic [DBG_W-1:0] dbg_calc;
    always_comb begin
        dbg_calc = '0;
        dbg_calc[3:0] = matched_breakpoints;
        dbg_calc[DBG_ENBP_BIT] = enbp_bit;
        dbg_calc[DBG_BS_BIT] = bs_bit;
    end
    wire logic [DBG_W-1:0] dbg_sel  = exit_after_entry ? entry_pending_debug : dbg_calc;
    wire logic [DBG_W-1:0] dbg_nxt  = dbg_keep ? (dbg_sel & DBG_VALID_MASK) : '0;

    logic [INTR_W-1:0] intr_nxt;
    always_comb begin
        intr_nxt = interruptibility;
        if (!exit_ends_in_smm) begin
            intr_nxt[SMI_BLK_BIT] = 1'b0;
        end
        if (virtual_nmi_ctl) begin
            intr_nxt[NMI_BLK_BIT] = virtual_nmi_blocked;
        end
    end

    wire logic [TMR_W-1:0] timer_nxt = timer_expiry_exit ? TMR_RESET : timer_value;
    wire logic pdpe_take = ept_supported & ept_enabled & pae_paging_active;

    // store-list entry checks
    wire logic [IDX_W-1:0] entry_idx = list_entry_lo[31:0];
    wire logic fail_apic  = (list_entry_lo[31:8] == APIC_IDX_HI);
    wire logic fail_hi    = (list_entry_lo[63:32] != 32'h0000_0000);
    wire logic fail_pre   = fail_apic | fail_hi;
    wire logic fail_post  = (msr_smm_only & ~smm_r) | msr_barred
                          | msr_gp_fault;
    wire logic list_end   = (idx_r >= cnt_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (exit_start) begin
                    state_nxt = ST_SAVE;
                end
            end
            ST_SAVE: begin
                state_nxt = ST_REQ;
            end
            ST_REQ: begin
                if (list_end) begin
                    state_nxt = ST_DONE;
                end else if (list_rd_valid) begin
                    state_nxt = fail_pre ? ST_DONE : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (msr_rd_valid) begin
                    state_nxt = fail_post ? ST_DONE : ST_REQ;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // saved state is taken in the exit_start cycle, before the list walk
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            saved_activity         <= '0;
            saved_interruptibility <= '0;
            saved_pending_debug    <= '0;
            saved_timer            <= TMR_RESET;
            saved_pdpe             <= '0;
            pdpe_saved             <= 1'b0;
            smm_r                  <= 1'b0;
            cnt_r                  <= '0;
        end else if (state_r == ST_IDLE && exit_start) begin
            saved_activity         <= activity_state;
            saved_interruptibility <= intr_nxt;
            saved_pending_debug    <= dbg_nxt;
            if (save_timer_ctl) begin
                saved_timer <= timer_nxt;
            end
            // present entries carry the guest-physical address as held
            if (pdpe_take) begin
                saved_pdpe <= pdpe_in_use;
            end
            pdpe_saved             <= pdpe_take;
            smm_r                  <= exit_ends_in_smm;
            // clamp guards against a runaway count
            cnt_r <= (store_count > CNT_W'(LIST_MAX)) ? CNT_W'(LIST_MAX) : store_count;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= ST_IDLE;
            idx_r     <= '0;
            msr_idx_r <= '0;
            abort_r   <= 1'b0;
            wr_en_r   <= 1'b0;
            wr_val_r  <= '0;
        end else begin
            state_r <= state_nxt;
            wr_en_r <= 1'b0;
            if (state_r == ST_IDLE && exit_start) begin
                idx_r   <= '0;
                abort_r <= 1'b0;
            end
            if (state_r == ST_REQ && !list_end && list_rd_valid) begin
                msr_idx_r <= entry_idx;
                if (fail_pre) begin
                    abort_r <= 1'b1;
                end
            end
            if (state_r == ST_WAIT && msr_rd_valid) begin
                if (fail_post) begin
                    abort_r <= 1'b1;
                end else begin
                    wr_en_r  <= 1'b1;
                    wr_val_r <= msr_value;
                    idx_r    <= idx_r + CNT_W'(1);
                end
            end
        end
    end

    assign list_rd_req   = (state_r == ST_REQ) && !list_end;
    assign list_index    = idx_r;
    assign msr_rd_req    = (state_r == ST_WAIT);
    assign msr_index     = msr_idx_r;
    assign list_wr_en    = wr_en_r;
    assign list_wr_value = wr_val_r;
    assign virt_abort    = abort_r & (state_r == ST_DONE);
    assign exit_done     = (state_r == ST_DONE);

    property p_smi_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && !exit_ends_in_smm) |=> !saved_interruptibility[2];
    endproperty
    a_smi_clear: assert property (p_smi_clear) else $error("smi blocking saved set");

    property p_dbg_zero;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && !dbg_keep) |=> (saved_pending_debug == 64'h0);
    endproperty
    a_dbg_zero: assert property (p_dbg_zero) else $error("pending debug not cleared");

    property p_reserved;
        @(posedge ref_clk) disable iff (!reset_n)
        (saved_pending_debug & ~DBG_VALID_MASK) == 64'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved debug bit set");

    property p_bs_blk;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && !exit_after_entry
         && (!trap_flag_setting || branch_trap_setting) && !exit_event_cause && !exit_reason_keep)
        |=> !saved_pending_debug[14];
    endproperty
    a_bs_blk: assert property (p_bs_blk) else $error("single step set illegally");

    property p_timer_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && !save_timer_ctl) |=> $stable(saved_timer);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer modified");

    property p_timer_zero;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && save_timer_ctl && timer_expiry_exit)
        |=> (saved_timer == 32'h0);
    endproperty
    a_timer_zero: assert property (p_timer_zero) else $error("expiry timer nonzero");

    sequence s_bad_entry;
        state_r == ST_REQ && !list_end && list_rd_valid && fail_pre;
    endsequence
    property p_abort_pre;
        @(posedge ref_clk) disable iff (!reset_n)
        s_bad_entry |=> virt_abort && !list_wr_en;
    endproperty
    a_abort_pre: assert property (p_abort_pre) else $error("no abort");

    property p_abort_post;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_WAIT && msr_rd_valid && fail_post) |=> virt_abort ##1 !exit_done;
    endproperty
    a_abort_post: assert property (p_abort_post) else $error("no abort on read fail");

    property p_store;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_WAIT && msr_rd_valid && !fail_post)
        |=> list_wr_en && list_wr_value == $past(msr_value);
    endproperty
    a_store: assert property (p_store) else $error("value not stored");

    property p_activity;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start) |=> saved_activity == $past(activity_state);
    endproperty
    a_activity: assert property (p_activity) else $error("activity not saved");

    property p_vnmi;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && virtual_nmi_ctl)
        |=> saved_interruptibility[NMI_BLK_BIT] == $past(virtual_nmi_blocked);
    endproperty
    a_vnmi: assert property (p_vnmi) else $error("virtual nmi blocking not saved");

    property p_pdpe_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_r == ST_IDLE && exit_start && !pdpe_take) |=> $stable(saved_pdpe) && !pdpe_saved;
    endproperty
    a_pdpe_hold: assert property (p_pdpe_hold) else $error("entries written");

    // a write beyond the sampled count would corrupt the next area
    property p_count;
        @(posedge ref_clk) disable iff (!reset_n)
        list_wr_en |-> (idx_r <= cnt_r) && (idx_r != '0);
    endproperty
    a_count: assert property (p_count) else $error("store past count");
endmodule

// *** verification/guest_exit_state_save_tb_top.sv ***
// self-checking bench for the guest exit state save block
module guest_exit_state_save_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import guest_exit_pkg::*;

    logic ref_clk = 1'b0, reset_n = 1'b0, exit_start = 1'b0;
    logic virtual_nmi_ctl = 1'b0, virtual_nmi_blocked = 1'b0, exit_ends_in_smm = 1'b0;
    logic exit_event_cause = 1'b0, exit_reason_keep = 1'b0, exit_is_debug = 1'b0;
    logic stack_move_debug_blocking = 1'b0, exit_after_entry = 1'b0;
    logic enabled_data_io_match = 1'b0, entry_bp_undelivered = 1'b0;
    logic trap_flag_setting = 1'b0, branch_trap_setting = 1'b0;
    logic single_step_cause = 1'b0, taken_branch_cause = 1'b0;
    logic save_timer_ctl = 1'b0, timer_expiry_exit = 1'b0;
    logic ept_supported = 1'b0, ept_enabled = 1'b0, pae_paging_active = 1'b0;
    logic list_rd_valid = 1'b0, msr_rd_valid = 1'b0;
    logic msr_smm_only = 1'b0, msr_barred = 1'b0, msr_gp_fault = 1'b0;
    logic [ACT_W-1:0]         activity_state = 32'h0;
    logic [INTR_W-1:0]        interruptibility = 32'h0;
    logic [DBG_W-1:0]         entry_pending_debug = 64'h0;
    logic [3:0]               matched_breakpoints = 4'h0;
    logic [TMR_W-1:0]         timer_value = 32'h0;
    logic [PDPE_W*PDPE_N-1:0] pdpe_in_use = 256'h0;
    logic [CNT_W-1:0]         store_count = 16'h0;
    logic [63:0]              list_entry_lo = 64'h0, msr_value = 64'h0;
    logic list_rd_req, msr_rd_req, list_wr_en, pdpe_saved, virt_abort, exit_done;
    logic [CNT_W-1:0]         list_index;
    logic [IDX_W-1:0]         msr_index;
    logic [63:0]              list_wr_value;
    logic [ACT_W-1:0]         saved_activity;
    logic [INTR_W-1:0]        saved_interruptibility;
    logic [DBG_W-1:0]         saved_pending_debug;
    logic [TMR_W-1:0]         saved_timer;
    logic [PDPE_W*PDPE_N-1:0] saved_pdpe;

    logic [63:0] ent [0:3];
    logic [63:0] bad [0:4];
    logic [31:0] smm_idx = 32'h9e, bar_idx = 32'hb0, gp_idx = 32'hc0;
    logic [63:0] wr_q [$];
    logic        abort;
    int          mismatches = 0, comparisons = 0, cycles = 0, i, k;

    // small list keeps the walk short
    guest_exit_state_save #(.LIST_MAX(4)) DUT (
        .ref_clk, .reset_n, .exit_start, .activity_state, .interruptibility,
        .virtual_nmi_ctl, .virtual_nmi_blocked, .exit_ends_in_smm, .exit_event_cause,
        .exit_reason_keep, .exit_is_debug, .stack_move_debug_blocking, .exit_after_entry,
        .entry_pending_debug, .matched_breakpoints, .enabled_data_io_match,
        .entry_bp_undelivered, .trap_flag_setting, .branch_trap_setting,
        .single_step_cause, .taken_branch_cause, .save_timer_ctl, .timer_expiry_exit,
        .timer_value, .ept_supported, .ept_enabled, .pae_paging_active, .pdpe_in_use,
        .store_count, .list_rd_req, .list_index, .list_rd_valid, .list_entry_lo,
        .msr_rd_req, .msr_index, .msr_rd_valid, .msr_value, .msr_smm_only, .msr_barred,
        .msr_gp_fault, .list_wr_en, .list_wr_value, .saved_activity,
        .saved_interruptibility, .saved_pending_debug, .saved_timer, .saved_pdpe,
        .pdpe_saved, .virt_abort, .exit_done);

    always #5 ref_clk = ~ref_clk;

    function automatic logic [63:0] mval(input logic [31:0] idx);
        return {idx ^ 32'h5a5a_0000, idx};
    endfunction

    // prompt responder: one-cycle valid, qualifiers with it
    always @(posedge ref_clk) begin
        list_rd_valid <= list_rd_req & ~list_rd_valid;
        list_entry_lo <= ent[list_index[1:0]];
        msr_rd_valid  <= msr_rd_req & ~msr_rd_valid;
        msr_value     <= mval(msr_index);
        msr_smm_only  <= (msr_index == smm_idx);
        msr_barred    <= (msr_index == bar_idx);
        msr_gp_fault  <= (msr_index == gp_idx);
        if (list_wr_en === 1'b1) begin
            wr_q.push_back(list_wr_value);
        end
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            $display("ERROR %0t run exceeded its cycle budget", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic run_exit(input logic [15:0] cnt);
        int n;
        wr_q.delete();
        @(posedge ref_clk);
        store_count <= cnt;
        exit_start  <= 1'b1;
        @(posedge ref_clk);
        exit_start <= 1'b0;
        n = 0;
        while (n < 100) begin
            @(posedge ref_clk);
            #1;
            if (exit_done === 1'b1) break;
            n++;
        end
        abort = virt_abort;
        if (n >= 100) begin
            mismatches++;
            $display("ERROR %0t exit never completed", $time);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        bad = '{64'h812, 64'h9e, 64'hb0, 64'h1_0000_0020, 64'hc0};
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        chk(list_rd_req, 1'b0, "request idle after reset");
        // plain exit, no keep case
        @(posedge ref_clk);
        activity_state <= 32'h3; interruptibility <= 32'hf; virtual_nmi_ctl <= 1'b1;
        entry_pending_debug <= 64'hffff_ffff_ffff_ffff; matched_breakpoints <= 4'h5;
        enabled_data_io_match <= 1'b1; trap_flag_setting <= 1'b1; single_step_cause <= 1'b1;
        save_timer_ctl <= 1'b1; timer_value <= 32'h1234;
        ept_supported <= 1'b1; ept_enabled <= 1'b1; pae_paging_active <= 1'b1;
        pdpe_in_use <= {64'h4001, 64'h3001, 64'h2001, 64'h1001};
        run_exit(16'h0);
        chk(saved_activity, 32'h3, "activity");
        chk(saved_interruptibility, 32'h3, "smi and virtual nmi blocking");
        chk(saved_pending_debug, 64'h0, "debug cleared");
        chk(saved_timer, 32'h1234, "timer saved");
        for (i = 0; i < 4; i++) begin
            chk(saved_pdpe[i*64 +: 64], pdpe_in_use[i*64 +: 64], "pdpe");
        end
        chk(pdpe_saved, 1'b1, "pdpe taken");
        chk(abort, 1'b0, "no abort");
        $display("test plain_exit done");
        // event-caused exits inside smm
        exit_event_cause <= 1'b1; exit_ends_in_smm <= 1'b1; virtual_nmi_ctl <= 1'b0;
        save_timer_ctl <= 1'b0; timer_value <= 32'h5678;
        pae_paging_active <= 1'b0;
        pdpe_in_use <= 256'h0;
        run_exit(16'h0);
        chk(saved_pending_debug, 64'h5005, "single step keep");
        chk(saved_interruptibility, 32'hf, "smm keeps blocking");
        chk(saved_timer, 32'h1234, "timer untouched");
        chk(pdpe_saved, 1'b0, "pdpe not taken");
        chk(saved_pdpe[63:0], 64'h1001, "pdpe held");
        branch_trap_setting <= 1'b1; single_step_cause <= 1'b0; taken_branch_cause <= 1'b1;
        enabled_data_io_match <= 1'b0; entry_bp_undelivered <= 1'b1;
        save_timer_ctl <= 1'b1; timer_expiry_exit <= 1'b1;
        run_exit(16'h0);
        chk(saved_pending_debug, 64'h5005, "taken branch keep");
        chk(saved_timer, 32'h0, "expiry saves zero");
        $display("test event_exit done");
        // stack-move blocking, non-debug then debug
        exit_event_cause <= 1'b0; stack_move_debug_blocking <= 1'b1; timer_expiry_exit <= 1'b0;
        entry_bp_undelivered <= 1'b0; enabled_data_io_match <= 1'b1;
        run_exit(16'h0);
        chk(saved_pending_debug, 64'h1005, "no step bit with branch trap");
        exit_after_entry <= 1'b1;
        run_exit(16'h0);
        chk(saved_pending_debug, 64'h500f, "entry value masked");
        exit_is_debug <= 1'b1; exit_after_entry <= 1'b0;
        run_exit(16'h0);
        chk(saved_pending_debug, 64'h0, "debug exit cleared");
        $display("test stack_move done");
        // store list: smm-only read allowed in smm, 0x900 just past the bad range
        stack_move_debug_blocking <= 1'b0; exit_is_debug <= 1'b0;
        ent = '{64'h10, 64'h9e, 64'h900, 64'h0};
        run_exit(16'h3);
        chk(wr_q.size(), 3, "store count");
        for (i = 0; i < 3; i++) chk(wr_q[i], mval(ent[i][31:0]), "store value");
        chk(abort, 1'b0, "good list no abort");
        $display("test store_list done");
        // one failing entry per kind, behind a good one
        exit_ends_in_smm <= 1'b0;
        for (k = 0; k < 5; k++) begin
            ent[1] = bad[k];
            run_exit(16'h2);
            chk(abort, 1'b1, "failing entry aborts");
            chk(wr_q[0], mval(32'h10), "entry before failure");
        end
        $display("test store_fail done");
        complete_run();
    end
endmodule
